//--- hdl/can_pm_pkg.sv
// can_pm_pkg: constants and types for the power-mode block
// assumes: single 20 MHz clock domain, no register bus
package can_pm_pkg;

    // timing
    localparam int unsigned CLK_HZ         = 20000000;
    localparam int unsigned RECESSIVE_JOIN = 11;    // bits before joining
    localparam int unsigned BUSOFF_GROUPS  = 128;   // recovery groups
    localparam int unsigned BUSOFF_GROUP   = 11;    // bits per group
    localparam int unsigned SEG1_MIN       = 4;
    localparam int unsigned SEG1_MAX       = 16;
    localparam int unsigned SEG2_MIN       = 2;
    localparam int unsigned SEG2_MAX       = 8;
    localparam int unsigned SJW_MIN        = 1;
    localparam int unsigned SJW_MAX        = 4;
    localparam int unsigned FILTER_LEN     = 8;     // glitch filter clocks

    // field widths
    localparam int unsigned SEG1_W  = 4;
    localparam int unsigned SEG2_W  = 3;
    localparam int unsigned SJW_W   = 2;
    localparam int unsigned PRESC_W = 6;

    // line levels
    localparam logic RECESSIVE = 1'b1;

    // mode of the controller
    typedef enum logic [2:0] {
        MODE_NORMAL,
        MODE_SLEEP_PEND,
        MODE_SLEEP,
        MODE_SYNC,
        MODE_SOFT_RESET,
        MODE_POWER_DOWN
    } mode_e;

    // bit timing, fields minus one: prescale in clock enables, others in quanta
    typedef struct packed {
        logic [PRESC_W-1:0] prescale;
        logic [SEG1_W-1:0]  first_segment_length;
        logic [SEG2_W-1:0]  second_segment_length;
        logic [SJW_W-1:0]   jump_width;
    } bit_timing_s;

    // control bits from software
    typedef struct packed {
        logic sleep_request;
        logic soft_reset_bit;
        logic wait_stop_bit;
        logic wakeup_filter_bit;
        logic wakeup_irq_enable;
        logic timer_pulse_enable;
        logic protocol_clock_select;
    } control_s;

    // protocol engine activity
    typedef struct packed {
        logic transmitting;
        logic tx_pending;
        logic receiving;
        logic frame_valid;
        logic bus_off;
        logic tx_bit;
    } engine_s;

endpackage : can_pm_pkg

//--- hdl/can_quanta_gen.sv
// can_quanta_gen: divides a protocol clock enable into quanta and bit phases
// assumes: clock enables arrive as one-cycle pulses on the system clock
`timescale 1ns/1ps
`default_nettype none

module can_quanta_gen
    import can_pm_pkg::*;
#(
    parameter int unsigned PW = PRESC_W
)
(
    // clock and reset
    input  wire logic                   clock,
    input  wire logic                   rst_n,
    // control
    input  wire logic                   run,
    input  wire logic                   src_en,
    input  wire can_pm_pkg::bit_timing_s timing,
    input  wire logic                   resync,
    // outputs
    output logic                        tq_en,
    output logic                        bit_en,
    output logic                        sample_en
);
    import can_pm_pkg::*;

    initial
    begin
        if (PW != PRESC_W) $error("bad prescaler width");
    end

    // ------------------------------------------------------------
    // prescaler and segment counters
    // ------------------------------------------------------------
    logic [PW-1:0]     presc_q;   // prescaler count
    logic [SEG1_W+1:0] tq_q;      // quantum index within bit
    logic [SEG1_W+1:0] bit_len;   // quanta per bit minus one
    logic [SEG1_W+1:0] sample_at; // quantum where sample is taken

    // total = 1 + (seg1+1) + (seg2+1), minus one
    assign bit_len   = (SEG1_W+2)'(timing.first_segment_length)
                     + (SEG1_W+2)'(timing.second_segment_length) + (SEG1_W+2)'(2);
    assign sample_at = (SEG1_W+2)'(timing.first_segment_length) + (SEG1_W+2)'(1);

    // prescaler makes the quantum enable
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            presc_q <= '0;
            tq_en   <= 1'b0;
        end
        else if (!run)
        begin
            presc_q <= '0;
            tq_en   <= 1'b0;
        end
        else if (src_en)
        begin
            tq_en   <= (presc_q == timing.prescale);
            presc_q <= (presc_q == timing.prescale) ? '0 : presc_q + 1'b1;
        end
        else
        begin
            tq_en <= 1'b0;
        end
    end

    // sync, first and second segment counting
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tq_q      <= '0;
            bit_en    <= 1'b0;
            sample_en <= 1'b0;
        end
        else if (!run)
        begin
            tq_q      <= '0;
            bit_en    <= 1'b0;
            sample_en <= 1'b0;
        end
        else if (tq_en)
        begin
            // hard resync on edge restarts at sync segment
            if (resync || tq_q >= bit_len)
            begin
                tq_q <= '0;
            end
            else
            begin
                tq_q <= tq_q + 1'b1;
            end
            bit_en    <= (tq_q >= bit_len);
            sample_en <= (tq_q == sample_at);
        end
        else
        begin
            bit_en    <= 1'b0;
            sample_en <= 1'b0;
        end
    end

endmodule : can_quanta_gen

`default_nettype wire

//--- hdl/can_power_mode_bit_timing.sv
// can_power_mode_bit_timing: low-power modes, wakeup, timer pulse and bit timing
// assumes: engine reports activity; clocks are enables on one clock
// Operation
// - transmitting: finish all scheduled messages, then sleep
// - receiving: finish current frame, then sleep
// - idle: enter sleep at once
// - sleep acknowledge held while asleep
// - sleep stops protocol clocks, freezes bus-off count
// - sleep: transmit recessive, no receive buffer copy
// - sleep: transmit buffers usable, aborts deferred
// - wake on bus activity, request clear, reset
// - request clear ignored until acknowledge set
// - after wakeup wait eleven recessive bits
// - wakeup runs deferred copy, abort, transmit
// - soft reset halts traffic immediately
// - power-down in stop, or wait with bit
// - power-down aborts, recessive, blocks registers
// - filter bit low-passes receive line asleep
// - one-bit pulse after every valid frame
// - pulse reaches timer only when enabled
// - clock select: crystal or bus clock
// - prescaler makes time quanta
// - sync one, seg1 4-16, seg2 2-8
// - jump width one to four quanta
// - wakeup interrupt needs acknowledge and enable
`timescale 1ns/1ps
`default_nettype none

module can_power_mode_bit_timing
    import can_pm_pkg::*;
#(
    parameter int unsigned FILT = FILTER_LEN
)
(
    // clock and reset
    input  wire logic                    clock,
    input  wire logic                    rst_n,
    // protocol clock sources, one-cycle enables
    input  wire logic                    crystal_clock,
    input  wire logic                    system_bus_clock,
    // cpu state
    input  wire logic                    cpu_stop,
    input  wire logic                    cpu_wait,
    // software control and configuration
    input  wire can_pm_pkg::control_s    ctrl,
    input  wire can_pm_pkg::bit_timing_s timing,
    input  wire logic                    sleep_request_clear,
    input  wire logic                    abort_request,
    // protocol engine
    input  wire can_pm_pkg::engine_s     engine,
    input  wire logic                    rx_full_pending,
    // line
    input  wire logic                    receive_line_in,
    output logic                         transmit_line_out,
    // status
    output logic                         sleep_request,
    output logic                         sleep_acknowledge,
    output logic                         soft_reset_active,
    output logic                         power_down,
    output logic                         register_access_ok,
    output logic                         engine_run,
    output logic                         bus_joined,
    output logic                         busoff_count_en,
    output logic                         rx_copy_en,
    output logic                         abort_en,
    output logic                         wakeup_irq,
    output logic                         timer_capture,
    // timing
    output logic                         quantum_tick,
    output logic                         bit_tick,
    output logic                         sample_tick,
    output logic [SJW_W:0]               jump_quanta
);
    import can_pm_pkg::*;

    initial
    begin
        if (FILT < 2 || FILT > 255) $error("filter length out of range");
    end

    // ------------------------------------------------------------
    // mode state
    // ------------------------------------------------------------
    mode_e       mode_q;        // current mode
    mode_e       mode_d;
    logic        slpreq_q;      // held sleep request bit
    logic [3:0]  rec_cnt_q;     // consecutive recessive bits after wake
    logic [7:0]  filt_cnt_q;    // glitch filter count
    logic        wake_evt;      // filtered bus activity
    logic        pd_cond;       // power-down condition
    logic        proto_en;      // selected protocol clock enable
    logic        run;           // protocol clocks running
    logic        tq_en;
    logic        bit_en;
    logic        sample_en;
    logic        rx_prev_q;     // previous line for edge detection
    logic        pulse_q;       // valid-frame pulse, one bit long
    logic        pulse_arm_q;   // pulse waiting for bit boundary

    // power-down when stopped, or waiting with wait-stop set
    assign pd_cond = cpu_stop || (cpu_wait && ctrl.wait_stop_bit);

    // clock source select
    assign proto_en = ctrl.protocol_clock_select ? system_bus_clock : crystal_clock;

    // next mode gates clocks, so nothing ticks once asleep
    assign run = (mode_d == MODE_NORMAL) || (mode_d == MODE_SLEEP_PEND)
              || (mode_d == MODE_SYNC);

    // bus activity is a dominant level, optionally filtered
    assign wake_evt = ctrl.wakeup_filter_bit
                    ? (filt_cnt_q == 8'(FILT - 1))
                    : (receive_line_in != RECESSIVE);

    // ------------------------------------------------------------
    // quanta and bit timing
    // ------------------------------------------------------------
    can_quanta_gen #(
        .PW (PRESC_W)
    ) u_quanta (
        .clock     (clock),
        .rst_n     (rst_n),
        .run       (run),
        .src_en    (proto_en),
        .timing    (timing),
        .resync    (1'b0),
        .tq_en     (tq_en),
        .bit_en    (bit_en),
        .sample_en (sample_en)
    );

    // ------------------------------------------------------------
    // sleep request bit
    // ------------------------------------------------------------
    // set by software; cleared by request clear or bus wakeup while asleep, or in soft reset
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            slpreq_q <= 1'b0;
        end
        else if (mode_q == MODE_POWER_DOWN)
        begin
            slpreq_q <= slpreq_q;              // register access blocked
        end
        else if (ctrl.sleep_request)
        begin
            slpreq_q <= 1'b1;
        end
        else if ((sleep_request_clear && mode_q == MODE_SLEEP) || mode_q == MODE_SOFT_RESET)
        begin
            slpreq_q <= 1'b0;
        end
        else if (mode_q == MODE_SLEEP && wake_evt)
        begin
            slpreq_q <= 1'b0;                  // bus wakeup drops request
        end
    end

    // ------------------------------------------------------------
    // mode transitions
    // ------------------------------------------------------------
    always_comb
    begin
        mode_d = mode_q;
        unique case (mode_q)
            MODE_NORMAL:
            begin
                if (slpreq_q)
                begin
                    mode_d = MODE_SLEEP_PEND;
                end
            end
            MODE_SLEEP_PEND:
            begin
                // wait out transmit queue and current frame
                if (!engine.transmitting && !engine.tx_pending && !engine.receiving)
                begin
                    mode_d = MODE_SLEEP;
                end
            end
            MODE_SLEEP:
            begin
                // two wake sources here: bus activity or request clear; soft reset overrides below
                if (wake_evt || (sleep_request_clear && !ctrl.sleep_request))
                begin
                    mode_d = MODE_SYNC;
                end
            end
            MODE_SYNC:
            begin
                // eleven recessive bits before joining
                if (bit_en && sample_en == 1'b0
                    && rec_cnt_q == 4'(RECESSIVE_JOIN - 1)
                    && receive_line_in == RECESSIVE)
                begin
                    mode_d = MODE_NORMAL;
                end
            end
            MODE_SOFT_RESET:
            begin
                if (!ctrl.soft_reset_bit)
                begin
                    mode_d = MODE_SYNC;
                end
            end
            MODE_POWER_DOWN:
            begin
                if (!pd_cond)
                begin
                    mode_d = slpreq_q ? MODE_SLEEP : MODE_SYNC;
                end
            end
        endcase
        // soft reset halts at once, overrides sleep
        if (ctrl.soft_reset_bit && mode_q != MODE_POWER_DOWN)
        begin
            mode_d = MODE_SOFT_RESET;
        end
        // power-down overrides everything
        if (pd_cond)
        begin
            mode_d = MODE_POWER_DOWN;
        end
    end

    // mode register
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mode_q <= MODE_SOFT_RESET;
        end
        else
        begin
            mode_q <= mode_d;
        end
    end

    // ------------------------------------------------------------
    // recessive-bit counter and glitch filter
    // ------------------------------------------------------------
    // counts consecutive recessive bits while synchronising
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rec_cnt_q <= '0;
        end
        else if (mode_q != MODE_SYNC)
        begin
            rec_cnt_q <= '0;
        end
        else if (bit_en)
        begin
            rec_cnt_q <= (receive_line_in == RECESSIVE) ? rec_cnt_q + 4'h1 : 4'h0;
        end
    end

    // dominant level must persist to count as activity
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            filt_cnt_q <= '0;
        end
        else if (mode_q != MODE_SLEEP || receive_line_in == RECESSIVE)
        begin
            filt_cnt_q <= '0;
        end
        else if (filt_cnt_q != 8'(FILT - 1))
        begin
            filt_cnt_q <= filt_cnt_q + 8'h01;
        end
    end

    // ------------------------------------------------------------
    // valid-frame timer pulse
    // ------------------------------------------------------------
    // arm on valid frame, hold high for one full bit
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pulse_arm_q <= 1'b0;
            pulse_q     <= 1'b0;
        end
        else if (!run)
        begin
            pulse_arm_q <= 1'b0;
            pulse_q     <= 1'b0;
        end
        else
        begin
            if (engine.frame_valid)
            begin
                pulse_arm_q <= 1'b1;
            end
            else if (bit_en)
            begin
                pulse_arm_q <= 1'b0;
            end
            if (bit_en)
            begin
                pulse_q <= pulse_arm_q;
            end
        end
    end

    // ------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------
    // line and status outputs
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            transmit_line_out  <= RECESSIVE;
            sleep_request      <= 1'b0;
            sleep_acknowledge  <= 1'b0;
            soft_reset_active  <= 1'b1;
            power_down         <= 1'b0;
            register_access_ok <= 1'b1;
            engine_run         <= 1'b0;
            bus_joined         <= 1'b0;
        end
        else
        begin
            // recessive unless actively on the bus
            transmit_line_out  <= (mode_d == MODE_NORMAL || mode_d == MODE_SLEEP_PEND)
                                  ? engine.tx_bit : RECESSIVE;
            sleep_request      <= slpreq_q;
            sleep_acknowledge  <= (mode_d == MODE_SLEEP);
            soft_reset_active  <= (mode_d == MODE_SOFT_RESET);
            power_down         <= (mode_d == MODE_POWER_DOWN);
            register_access_ok <= (mode_d != MODE_POWER_DOWN);
            engine_run         <= (mode_d == MODE_NORMAL || mode_d == MODE_SLEEP_PEND);
            bus_joined         <= (mode_d == MODE_NORMAL || mode_d == MODE_SLEEP_PEND);
        end
    end

    // deferred work, wakeup irq, timer link
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            busoff_count_en <= 1'b0;
            rx_copy_en      <= 1'b0;
            abort_en        <= 1'b0;
            wakeup_irq      <= 1'b0;
            timer_capture   <= 1'b0;
        end
        else
        begin
            // bus-off count freezes asleep, resumes after
            busoff_count_en <= engine.bus_off && run && bit_en;
            // buffer copy and aborts wait for wake
            rx_copy_en      <= run;
            abort_en        <= run && abort_request;
            // wakeup irq only when acknowledged and enabled
            wakeup_irq      <= sleep_acknowledge && ctrl.wakeup_irq_enable
                               && mode_q == MODE_SLEEP && wake_evt;
            // gate pulse onto timer capture input
            timer_capture   <= pulse_q && ctrl.timer_pulse_enable;
        end
    end

    // timing ticks and jump width in quanta
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            quantum_tick <= 1'b0;
            bit_tick     <= 1'b0;
            sample_tick  <= 1'b0;
            jump_quanta  <= '0;
        end
        else
        begin
            quantum_tick <= tq_en;
            bit_tick     <= bit_en;
            sample_tick  <= sample_en;
            jump_quanta  <= {1'b0, timing.jump_width} + (SJW_W+1)'(1);
        end
    end

endmodule : can_power_mode_bit_timing

`default_nettype wire

//--- dv/can_pm_checker_properties.sv
// can_pm_checker: power-mode assertions
// assumes: bound into the block, one clock
`timescale 1ns/1ps
`default_nettype none

module can_pm_checker
    import can_pm_pkg::*;
(
    // inputs
    input wire logic                    clock,
    input wire logic                    rst_n,
    input wire can_pm_pkg::control_s    ctrl,
    input wire can_pm_pkg::bit_timing_s timing,
    input wire can_pm_pkg::engine_s     engine,
    input wire logic                    cpu_stop,
    input wire logic                    sleep_request_clear,
    // outputs
    input wire logic                    transmit_line_out,
    input wire logic                    sleep_request,
    input wire logic                    sleep_acknowledge,
    input wire logic                    soft_reset_active,
    input wire logic                    power_down,
    input wire logic                    register_access_ok,
    input wire logic                    engine_run,
    input wire logic                    bus_joined,
    input wire logic                    busoff_count_en,
    input wire logic                    rx_copy_en,
    input wire logic                    abort_en,
    input wire logic                    wakeup_irq,
    input wire logic                    timer_capture,
    input wire logic                    quantum_tick,
    input wire logic [SJW_W:0]          jump_quanta
);
    // ----
    // properties
    // ----
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);

    a_pd_line_off: assert property (power_down |-> transmit_line_out && !register_access_ok)
        else $error("power-down leak");
    a_stop_powers_down: assert property (cpu_stop |-> ##[1:2] power_down)
        else $error("no power-down");
    a_sleep_quiet: assert property (sleep_acknowledge |-> transmit_line_out && !rx_copy_en && !abort_en)
        else $error("busy asleep");
    a_sleep_frozen: assert property (sleep_acknowledge && $past(sleep_acknowledge) |-> !busoff_count_en && !quantum_tick)
        else $error("clock asleep");
    a_clear_refused: assert property (sleep_request && !sleep_acknowledge && sleep_request_clear
        && !ctrl.soft_reset_bit |=> sleep_request)
        else $error("early clear");
    a_idle_sleeps: assert property (ctrl.sleep_request && bus_joined && !sleep_request
        && engine[5:3] == 3'h0 |-> ##[1:4] sleep_acknowledge)
        else $error("idle sleep late");
    a_reset_halts: assert property (ctrl.soft_reset_bit && !power_down |-> ##[1:3] (soft_reset_active && !engine_run))
        else $error("no halt");
    a_timer_gated: assert property (timer_capture |-> ctrl.timer_pulse_enable)
        else $error("pulse gated off");
    a_irq_after_sleep: assert property (wakeup_irq |-> ctrl.wakeup_irq_enable
        && ($past(sleep_acknowledge) || $past(sleep_acknowledge, 2)))
        else $error("stray irq");
    a_jump_quanta: assert property ($past(rst_n) && $stable(timing.jump_width)
        |-> jump_quanta == timing.jump_width + 3'h1)
        else $error("bad jump");
endmodule : can_pm_checker

bind can_power_mode_bit_timing can_pm_checker checker_i (.*);
`default_nettype wire

//--- dv/can_bus_model.sv
// can_bus_model: wired-and bus line
// assumes: bench drives other nodes
`timescale 1ns/1ps
`default_nettype none

module can_bus_model
(
    // line
    input  wire logic tx_line,   // our level
    input  wire logic dominant,  // other node low
    output logic      rx_line    // to the block
);
    // any dominant node wins
    always_comb rx_line = tx_line & ~dominant;
endmodule : can_bus_model
`default_nettype wire

//--- dv/testbench.sv
// testbench: sleep, wake, timing, pulse, power-down
// assumes: bus model on line, checker bound
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import can_pm_pkg::*;

    logic clock = 1'b0, rst_n = 1'b0, crystal_clock = 1'b1, system_bus_clock = 1'b0;
    logic cpu_stop = 1'b0, cpu_wait = 1'b0, dominant = 1'b0, abort_request = 1'b0;
    logic sleep_request_clear = 1'b0, rx_full_pending = 1'b0;
    control_s    ctrl = 7'h2c;  // reset, filter, irq on
    bit_timing_s timing = '0;
    engine_s     engine = 6'h01;  // idle, recessive bit
    logic receive_line_in, transmit_line_out, sleep_request, sleep_acknowledge, bus_joined;
    logic soft_reset_active, power_down, register_access_ok, engine_run, busoff_count_en;
    logic rx_copy_en, abort_en, wakeup_irq, timer_capture, quantum_tick, bit_tick, sample_tick;
    logic [SJW_W:0] jump_quanta;
    logic [15:0]    lfsr_q = 16'h2a0c;  // seed
    int miscompares = 0, cmp_count = 0, cycles = 0, n, p;

    can_power_mode_bit_timing #(.FILT(4)) dut (.*);
    can_bus_model bus (.tx_line(transmit_line_out), .dominant(dominant), .rx_line(receive_line_in));

    // clock and hang guard
    always #25 clock = ~clock;
    always @(posedge clock)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            miscompares++;
            end_of_test();
        end
    end

    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next
    // clocks per bit
    function automatic int bit_len(input bit_timing_s t);
        return (t.prescale + 1) * (3 + t.first_segment_length + t.second_segment_length);
    endfunction : bit_len
    task automatic tick(input int k);
        repeat (k) @(posedge clock);
        #2;
    endtask : tick
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    // bounded wait, cycles in n
    task automatic wait_for(ref logic s, input logic v, input int lim);
        n = 0;
        while (s !== v && n < lim)
        begin
            tick(1);
            n++;
        end
        check(s, v);
    endtask : wait_for
    task automatic clear_pulse();
        sleep_request_clear = 1'b1;
        tick(1);
        sleep_request_clear = 1'b0;
    endtask : clear_pulse
    task automatic end_of_test();
        $display("cmp %0d err %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : end_of_test

    initial
    begin
        tick(5);
        rst_n = 1'b1;
        check(transmit_line_out, RECESSIVE);
        // min, max, random timing
        for (int i = 0; i < 3; i++)
        begin
            ctrl.soft_reset_bit = 1'b1;
            tick(2);
            lfsr_q = lfsr_next(lfsr_q);
            timing = (i == 0) ? {6'h00, 4'h3, 3'h1, 2'h0} : (i == 1) ? {6'h03, 4'hf, 3'h7, 2'h3}
                   : {4'h0, lfsr_q[1:0], (lfsr_q[5:2] < 3) ? 4'h3 : lfsr_q[5:2],
                          (lfsr_q[8:6] == 0) ? 3'h1 : lfsr_q[8:6], lfsr_q[10:9]};
            ctrl.protocol_clock_select = i[0];
            crystal_clock = ~i[0];
            system_bus_clock = i[0];
            tick(1);
            ctrl.soft_reset_bit = 1'b0;
            p = bit_len(timing);
            wait_for(bus_joined, 1'b1, 4000);
            check(jump_quanta, timing.jump_width + 3'h1);
            wait_for(bit_tick, 1'b1, 200);
            tick(1);
            wait_for(bit_tick, 1'b1, 200);
            check(n + 1, p);
        end
        // sleep busy or idle; wake by clear, bus, reset
        for (int k = 0; k < 3; k++)
        begin
            engine = {k == 0, k == 0, k == 1, 3'h1};
            ctrl.sleep_request = 1'b1;
            tick(1);
            ctrl.sleep_request = 1'b0;
            if (k < 2)
            begin
                tick(6);
                check(sleep_acknowledge, 1'b0);
                clear_pulse();
                tick(2);
                check(sleep_request, 1'b1);
            end
            engine = 6'h01;
            wait_for(sleep_acknowledge, 1'b1, 10);
            abort_request = (k == 0);
            tick(20);
            check(sleep_acknowledge, 1'b1);
            if (k == 0)
                clear_pulse();
            if (k == 1)
            begin
                dominant = 1'b1;
                tick(1);
                dominant = 1'b0;
                tick(6);
                check(sleep_acknowledge, 1'b1);
                dominant = 1'b1;
                wait_for(wakeup_irq, 1'b1, 20);
                dominant = 1'b0;
            end
            if (k == 2)
            begin
                ctrl.soft_reset_bit = 1'b1;
                tick(3);
                check({sleep_acknowledge, soft_reset_active, engine_run}, 3'b010);
                ctrl.soft_reset_bit = 1'b0;
            end
            else
                wait_for(sleep_acknowledge, 1'b0, 20);
            wait_for(bus_joined, 1'b1, 4000);
            check(n >= 10 * p, 1'b1);
            if (k == 0)
                check(abort_en, 1'b1);
            abort_request = 1'b0;
        end
        // frame pulse, gated then passed
        for (int j = 0; j < 2; j++)
        begin
            ctrl.timer_pulse_enable = j[0];
            engine.frame_valid = 1'b1;
            tick(1);
            engine.frame_valid = 1'b0;
            if (j == 0)
                tick(2 * p + 4);
            wait_for(timer_capture, j[0], p + 4);
            if (j == 1)
            begin
                wait_for(timer_capture, 1'b0, p + 4);
                check(n, p);
            end
        end
        // stop, wait+bit, wait, while sending
        engine = 6'h20;
        for (int j = 0; j < 3; j++)
        begin
            cpu_stop = (j == 0);
            cpu_wait = (j > 0);
            ctrl.wait_stop_bit = (j == 1);
            tick(4);
            check({power_down, register_access_ok, transmit_line_out | (j == 2)},
                  (j < 2) ? 3'b101 : 3'b011);
            cpu_stop = 1'b0;
            cpu_wait = 1'b0;
            tick(4);
        end
        end_of_test();
    end
endmodule : testbench
`default_nettype wire
